// [verilog/lgwc_pkg.sv]
package lgwc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus geometry: byte address is four times the register index
   localparam int unsigned ADDR_W    = 12;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned IDX_LSB   = 2;
   localparam int unsigned IDX_MSB   = 9;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices
   localparam logic [7:0] IDX_ACT       = 8'h30;
   localparam logic [7:0] IDX_BASE_HI   = 8'h60;
   localparam logic [7:0] IDX_BASE_LO   = 8'h61;
   localparam logic [7:0] IDX_PORT_BASE = 8'hE0;
   localparam logic [7:0] IDX_P5_DIR    = 8'hE0;
   localparam logic [7:0] IDX_P5_DATA   = 8'hE1;
   localparam logic [7:0] IDX_P5_INV    = 8'hE2;
   localparam logic [7:0] IDX_P5_STAT   = 8'hE3;
   localparam logic [7:0] IDX_P6_DIR    = 8'hE4;
   localparam logic [7:0] IDX_P6_DATA   = 8'hE5;
   localparam logic [7:0] IDX_P6_INV    = 8'hE6;
   localparam logic [7:0] IDX_P6_STAT   = 8'hE7;
   localparam logic [7:0] IDX_WD_MODE   = 8'hF5;
   localparam logic [7:0] IDX_WD_COUNT  = 8'hF6;
   localparam logic [7:0] IDX_WD_CTRL   = 8'hF7;

   // Offsets inside one port's group of four
   localparam int unsigned PORT_STRIDE  = 4;
   localparam int unsigned OFF_DIR      = 0;
   localparam int unsigned OFF_DATA     = 1;
   localparam int unsigned OFF_INV      = 2;
   localparam int unsigned OFF_STAT     = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_ACT       = 8'h02;
   localparam logic [7:0] RST_BASE      = 8'h00;
   localparam logic [7:0] RST_DIR       = 8'hFF;
   localparam logic [7:0] RST_P5_DATA   = 8'h00;
   localparam logic [7:0] RST_P6_DATA   = 8'h1F;
   localparam logic [7:0] RST_ZERO      = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and writable masks
   localparam int unsigned ACT_WD_BIT     = 0;
   localparam int unsigned ACT_P5_BIT     = 1;
   localparam int unsigned ACT_P6_BIT     = 2;
   localparam logic [7:0]  ACT_MASK       = 8'h07;
   localparam logic [7:0]  BASE_LO_MASK   = 8'hFC;
   localparam int unsigned MODE_KEYBOARD_RESET_PIN_BIT = 1;
   localparam int unsigned MODE_KBC_BIT   = 2;
   localparam int unsigned MODE_MIN_BIT   = 3;
   localparam int unsigned MODE_FAST_BIT  = 4;
   localparam logic [7:0]  MODE_MASK      = 8'h1E;
   localparam int unsigned CTRL_STAT_BIT  = 4;
   localparam int unsigned CTRL_TRIG_BIT  = 5;
   localparam logic [7:0]  CTRL_KEEP_MASK = 8'hCF;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SEC_UNIT_S    = 1;
   localparam int unsigned MIN_UNIT_S    = 60;
   localparam int unsigned FAST_DIV      = 1000;
   localparam int unsigned SEC_CYC       = CLK_HZ * SEC_UNIT_S;
   localparam int unsigned MIN_CYC       = CLK_HZ * MIN_UNIT_S;
   localparam int unsigned KB_PULSE_NS   = 1000;
   localparam int unsigned KB_PULSE_CYC  = (KB_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  KB_PULSE_LEN  = 8'(KB_PULSE_CYC);

endpackage

// [verilog/lgwc_wdog_if.sv]
`timescale 1ns/10ps
interface lgwc_wdog_if;
   logic       load;
   logic [7:0] load_val;
   logic       unit_min;
   logic       fast;
   logic       kbc_evt_en;
   logic       keyboard_reset_pin_en;
   logic       kbc_rise;
   logic       sw_trig;
   logic       sw_clr;
   logic [7:0] count;
   logic       expired;
   logic       keyboard_reset_pin_pulse;

   modport ctrl (output load, load_val, unit_min, fast, kbc_evt_en, keyboard_reset_pin_en,
                 output kbc_rise, sw_trig, sw_clr,
                 input  count, expired, keyboard_reset_pin_pulse);
   modport timer (input  load, load_val, unit_min, fast, kbc_evt_en, keyboard_reset_pin_en,
                  input  kbc_rise, sw_trig, sw_clr,
                  output count, expired, keyboard_reset_pin_pulse);
endinterface

// [verilog/lgwc_wdog.sv]
`timescale 1ns/10ps
module lgwc_wdog #(
   parameter int unsigned SEC_CYCLES = lgwc_pkg::SEC_CYC,
   parameter int unsigned MIN_CYCLES = lgwc_pkg::MIN_CYC
) (
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   lgwc_wdog_if.timer  wd
);

   localparam logic [31:0] SEC_LAST  = 32'(SEC_CYCLES - 1);
   localparam logic [31:0] MIN_LAST  = 32'(MIN_CYCLES - 1);
   localparam logic [31:0] FSEC_LAST = 32'(SEC_CYCLES / lgwc_pkg::FAST_DIV - 1);
   localparam logic [31:0] FMIN_LAST = 32'(MIN_CYCLES / lgwc_pkg::FAST_DIV - 1);

   logic [31:0] presc_reg;
   logic [31:0] presc_next;
   logic [7:0]  count_reg;
   logic [7:0]  count_next;
   logic        expired_reg;
   logic        expired_next;
   logic [7:0]  pulse_reg;
   logic [7:0]  pulse_next;

   wire [31:0] unit_last = wd.unit_min ? (wd.fast ? FMIN_LAST : MIN_LAST)
                                       : (wd.fast ? FSEC_LAST : SEC_LAST);
   wire running = (count_reg != 8'h00);
   wire tick    = running && (presc_reg >= unit_last);
   wire expire  = tick && (count_reg == 8'h01);
   wire timeout = expire | (wd.kbc_evt_en & wd.kbc_rise) | wd.sw_trig;

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler restarts on every load so the first unit is a full one
   assign presc_next   = (wd.load || !running || tick) ? 32'h0000_0000 : presc_reg + 32'h0000_0001;
   assign count_next   = wd.load ? wd.load_val
                                 : (tick ? count_reg - 8'h01 : count_reg);
   // Set beats a same-cycle software clear
   assign expired_next = timeout ? 1'b1
                                 : ((wd.sw_clr || wd.load) ? 1'b0 : expired_reg);
   assign pulse_next   = (timeout && wd.keyboard_reset_pin_en) ? lgwc_pkg::KB_PULSE_LEN
                                 : ((pulse_reg != 8'h00) ? pulse_reg - 8'h01 : pulse_reg);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         presc_reg   <= 32'h0000_0000;
         count_reg   <= 8'h00;
         expired_reg <= 1'b0;
         pulse_reg   <= 8'h00;
      end else begin
         presc_reg   <= presc_next;
         count_reg   <= count_next;
         expired_reg <= expired_next;
         pulse_reg   <= pulse_next;
      end
   end

   assign wd.count       = count_reg;
   assign wd.expired     = expired_reg;
   assign wd.keyboard_reset_pin_pulse = (pulse_reg != 8'h00);

endmodule

// [verilog/lgwc_top.sv]
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
module lgwc_top #(
   parameter int unsigned SEC_CYCLES = lgwc_pkg::SEC_CYC,
   parameter int unsigned MIN_CYCLES = lgwc_pkg::MIN_CYC
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic [7:0]  PORT_FIVE_PINS_I,
   output logic      [7:0]  PORT_FIVE_PINS_O,
   output logic      [7:0]  PORT_FIVE_PINS_OE_O,
   input  wire logic [7:0]  PORT_SIX_PINS_I,
   output logic      [7:0]  PORT_SIX_PINS_O,
   output logic      [7:0]  PORT_SIX_PINS_OE_O,
   input  wire logic        KEYBOARD_CTRL_RESET_LINE_I,
   output logic             KEYBOARD_RESET_PIN_O,
   output logic             KEYBOARD_RESET_PIN_OE_O,
   output logic             WATCHDOG_TIMEOUT_OUT_N_O,
   output logic             POWER_LED_O,
   output logic      [15:0] PORT_BASE_ADDR_O
);

   localparam int unsigned NPORT = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Index of a register inside a port's group
   function automatic logic [7:0] port_idx(input int unsigned p, input int unsigned off);
      port_idx = 8'(lgwc_pkg::IDX_PORT_BASE + lgwc_pkg::PORT_STRIDE * p + off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire [7:0] idx       = PADDR_I[lgwc_pkg::IDX_MSB:lgwc_pkg::IDX_LSB];
   wire       addr_ok   = (PADDR_I[11:10] == 2'h0) && (PADDR_I[1:0] == 2'h0);
   wire       acc_phase = PSEL_I & PENABLE_I;
   wire       set_phase = PSEL_I & ~PENABLE_I;
   logic      mapped;
   wire       wr_en     = acc_phase & PWRITE_I & addr_ok & mapped;
   wire       rd_setup  = set_phase & ~PWRITE_I;
   wire       rd_acc    = acc_phase & ~PWRITE_I & addr_ok;
   wire [7:0] wdata     = PWDATA_I[7:0];

   // Zero wait states; error only for unmapped or misaligned words
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = acc_phase & ~(addr_ok & mapped);

   ////////////////////////////////////////////////////////////////////////////
   // Function and base address registers
   logic [7:0] act_reg;
   logic [7:0] act_next;
   logic [7:0] base_hi_reg;
   logic [7:0] base_hi_next;
   logic [7:0] base_lo_reg;
   logic [7:0] base_lo_next;
   logic [7:0] mode_reg;
   logic [7:0] mode_next;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;

   wire wr_act   = wr_en && (idx == lgwc_pkg::IDX_ACT);
   wire wr_bhi   = wr_en && (idx == lgwc_pkg::IDX_BASE_HI);
   wire wr_blo   = wr_en && (idx == lgwc_pkg::IDX_BASE_LO);
   wire wr_mode  = wr_en && (idx == lgwc_pkg::IDX_WD_MODE);
   wire wr_count = wr_en && (idx == lgwc_pkg::IDX_WD_COUNT);
   wire wr_ctrl  = wr_en && (idx == lgwc_pkg::IDX_WD_CTRL);

   assign act_next     = wr_act  ? (wdata & lgwc_pkg::ACT_MASK) : act_reg;
   assign base_hi_next = wr_bhi  ? wdata : base_hi_reg;
   // Low two address bits held at zero for word alignment
   assign base_lo_next = wr_blo  ? (wdata & lgwc_pkg::BASE_LO_MASK) : base_lo_reg;
   assign mode_next    = wr_mode ? (wdata & lgwc_pkg::MODE_MASK) : mode_reg;
   assign ctrl_next    = wr_ctrl ? (wdata & lgwc_pkg::CTRL_KEEP_MASK) : ctrl_reg;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         act_reg     <= lgwc_pkg::RST_ACT;
         base_hi_reg <= lgwc_pkg::RST_BASE;
         base_lo_reg <= lgwc_pkg::RST_BASE;
         mode_reg    <= lgwc_pkg::RST_ZERO;
         ctrl_reg    <= lgwc_pkg::RST_ZERO;
      end else begin
         act_reg     <= act_next;
         base_hi_reg <= base_hi_next;
         base_lo_reg <= base_lo_next;
         mode_reg    <= mode_next;
         ctrl_reg    <= ctrl_next;
      end
   end

   wire wd_active = act_reg[lgwc_pkg::ACT_WD_BIT];
   wire [NPORT-1:0] port_act = {act_reg[lgwc_pkg::ACT_P6_BIT],
                                act_reg[lgwc_pkg::ACT_P5_BIT]};

   assign PORT_BASE_ADDR_O = {base_hi_reg, base_lo_reg};

   ////////////////////////////////////////////////////////////////////////////
   // Read capture; the captured status byte is also the clear mask
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [7:0]  rd_mux;

   assign prdata_next = rd_setup ? ((addr_ok && mapped) ? {24'h00_0000, rd_mux} : 32'h0000_0000)
                                 : prdata_reg;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign PRDATA_O = prdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // General-purpose ports
   wire  [NPORT-1:0][7:0] pin_in = {PORT_SIX_PINS_I, PORT_FIVE_PINS_I};
   logic [NPORT-1:0][7:0] dir_w;
   logic [NPORT-1:0][7:0] inv_w;
   logic [NPORT-1:0][7:0] stat_w;
   logic [NPORT-1:0][7:0] data_rd_w;
   logic [NPORT-1:0][7:0] pin_out_w;
   logic [NPORT-1:0][7:0] pin_oe_w;

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp = gp + 1) begin : g_port
         localparam logic [7:0] DATA_RST = (gp == 0) ? lgwc_pkg::RST_P5_DATA : lgwc_pkg::RST_P6_DATA;

         logic [7:0] dir_reg;
         logic [7:0] dir_next;
         logic [7:0] data_reg;
         logic [7:0] data_next;
         logic [7:0] inv_reg;
         logic [7:0] inv_next;
         logic [7:0] stat_reg;
         logic [7:0] stat_next;
         logic [7:0] sync1_reg;
         logic [7:0] sync2_reg;
         logic [7:0] prev_reg;

         wire wr_dir  = wr_en && (idx == port_idx(gp, lgwc_pkg::OFF_DIR));
         wire wr_data = wr_en && (idx == port_idx(gp, lgwc_pkg::OFF_DATA));
         wire wr_inv  = wr_en && (idx == port_idx(gp, lgwc_pkg::OFF_INV));
         wire rd_stat = rd_acc && (idx == port_idx(gp, lgwc_pkg::OFF_STAT));

         // Any transition of the synchronized level, while the port is active
         wire [7:0] edge_hit = (sync2_reg ^ prev_reg) & {8{port_act[gp]}};
         wire [7:0] clr_mask = rd_stat ? prdata_reg[7:0] : 8'h00;

         assign dir_next  = wr_dir ? wdata : dir_reg;
         // Only bits programmed as outputs take the written value
         assign data_next = wr_data ? ((wdata & ~dir_reg) | (data_reg & dir_reg))
                                    : data_reg;
         assign inv_next  = wr_inv ? wdata : inv_reg;
         // Clear only what the read returned; a new edge always sets
         assign stat_next = (stat_reg & ~clr_mask) | edge_hit;

         always_ff @(posedge CLK_I) begin
            if (!RST_N_I) begin
               dir_reg   <= lgwc_pkg::RST_DIR;
               data_reg  <= DATA_RST;
               inv_reg   <= lgwc_pkg::RST_ZERO;
               stat_reg  <= lgwc_pkg::RST_ZERO;
               sync1_reg <= 8'h00;
               sync2_reg <= 8'h00;
               prev_reg  <= 8'h00;
            end else begin
               dir_reg   <= dir_next;
               data_reg  <= data_next;
               inv_reg   <= inv_next;
               stat_reg  <= stat_next;
               sync1_reg <= pin_in[gp];
               sync2_reg <= sync1_reg;
               prev_reg  <= sync2_reg;
            end
         end

         assign dir_w[gp]     = dir_reg;
         assign inv_w[gp]     = inv_reg;
         assign stat_w[gp]    = stat_reg;
         assign data_rd_w[gp] = (data_reg & ~dir_reg) | ((sync2_reg ^ inv_reg) & dir_reg);
         assign pin_out_w[gp] = data_reg ^ inv_reg;
         // Inactive port floats every pin
         assign pin_oe_w[gp]  = ~dir_reg & {8{port_act[gp]}};
      end
   endgenerate

   assign PORT_FIVE_PINS_O    = pin_out_w[0];
   assign PORT_FIVE_PINS_OE_O = pin_oe_w[0];
   assign PORT_SIX_PINS_O     = pin_out_w[1];
   assign PORT_SIX_PINS_OE_O  = pin_oe_w[1];

   ////////////////////////////////////////////////////////////////////////////
   // Keyboard controller reset line
   logic kbc_sync1_reg;
   logic kbc_sync2_reg;
   logic kbc_prev_reg;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         kbc_sync1_reg <= 1'b0;
         kbc_sync2_reg <= 1'b0;
         kbc_prev_reg  <= 1'b0;
      end else begin
         kbc_sync1_reg <= KEYBOARD_CTRL_RESET_LINE_I;
         kbc_sync2_reg <= kbc_sync1_reg;
         kbc_prev_reg  <= kbc_sync2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog timer
   lgwc_wdog_if wd_if ();

   assign wd_if.load       = wr_count;
   assign wd_if.load_val   = wdata;
   assign wd_if.unit_min   = mode_reg[lgwc_pkg::MODE_MIN_BIT];
   assign wd_if.fast       = mode_reg[lgwc_pkg::MODE_FAST_BIT];
   assign wd_if.kbc_evt_en = mode_reg[lgwc_pkg::MODE_KBC_BIT];
   // Reset pulse routed only while the watchdog function is active
   assign wd_if.keyboard_reset_pin_en   = mode_reg[lgwc_pkg::MODE_KEYBOARD_RESET_PIN_BIT] & wd_active;
   assign wd_if.kbc_rise   = kbc_sync2_reg & ~kbc_prev_reg;
   assign wd_if.sw_trig    = wr_ctrl & wdata[lgwc_pkg::CTRL_TRIG_BIT];
   assign wd_if.sw_clr     = wr_ctrl & ~wdata[lgwc_pkg::CTRL_STAT_BIT];

   lgwc_wdog #(
      .SEC_CYCLES (SEC_CYCLES),
      .MIN_CYCLES (MIN_CYCLES)
   ) u_wdog (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .wd      (wd_if.timer)
   );

   assign WATCHDOG_TIMEOUT_OUT_N_O = ~(wd_active & wd_if.expired);
   assign POWER_LED_O              = wd_active;
   // Open drain: only ever pulls low
   assign KEYBOARD_RESET_PIN_O     = 1'b0;
   assign KEYBOARD_RESET_PIN_OE_O  = wd_if.keyboard_reset_pin_pulse;

   ////////////////////////////////////////////////////////////////////////////
   // Read selection
   wire [7:0] ctrl_rd = {ctrl_reg[7:6], 1'b0, wd_if.expired, ctrl_reg[3:0]};

   always_comb begin
      mapped = 1'b1;
      rd_mux = 8'h00;
      case (idx)
         lgwc_pkg::IDX_ACT: begin
            rd_mux = act_reg;
         end
         lgwc_pkg::IDX_BASE_HI: begin
            rd_mux = base_hi_reg;
         end
         lgwc_pkg::IDX_BASE_LO: begin
            rd_mux = base_lo_reg;
         end
         lgwc_pkg::IDX_P5_DIR: begin
            rd_mux = dir_w[0];
         end
         lgwc_pkg::IDX_P5_DATA: begin
            rd_mux = data_rd_w[0];
         end
         lgwc_pkg::IDX_P5_INV: begin
            rd_mux = inv_w[0];
         end
         lgwc_pkg::IDX_P5_STAT: begin
            rd_mux = stat_w[0];
         end
         lgwc_pkg::IDX_P6_DIR: begin
            rd_mux = dir_w[1];
         end
         lgwc_pkg::IDX_P6_DATA: begin
            rd_mux = data_rd_w[1];
         end
         lgwc_pkg::IDX_P6_INV: begin
            rd_mux = inv_w[1];
         end
         lgwc_pkg::IDX_P6_STAT: begin
            rd_mux = stat_w[1];
         end
         lgwc_pkg::IDX_WD_MODE: begin
            rd_mux = mode_reg;
         end
         lgwc_pkg::IDX_WD_COUNT: begin
            rd_mux = wd_if.count;
         end
         lgwc_pkg::IDX_WD_CTRL: begin
            rd_mux = ctrl_rd;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

endmodule

// [verif/lgwc_asserts.sv]
`timescale 1ns/10ps
module lgwc_asserts (
   input wire logic        CLK_I,
   input wire logic        RST_N_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PSLVERR_O,
   input wire logic        KEYBOARD_RESET_PIN_OE_O,
   input wire logic        WATCHDOG_TIMEOUT_OUT_N_O,
   input wire logic        POWER_LED_O,
   input wire logic [15:0] PORT_BASE_ADDR_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   wire wr = PSEL_I && PENABLE_I && PWRITE_I;
   ////////////////////////////////////////////////////////////
   a_led_write: assert property (wr && PADDR_I == 12'h0C0 |=> POWER_LED_O == $past(PWDATA_I[0]))
      else $error("led not following activation write");
   a_watchdog_timeout_out_gated: assert property (!WATCHDOG_TIMEOUT_OUT_N_O |-> POWER_LED_O)
      else $error("timeout output while inactive");
   a_base_low: assert property (wr && PADDR_I == 12'h184 |=> PORT_BASE_ADDR_O[7:0] == ($past(PWDATA_I[7:0]) & 8'hFC))
      else $error("base low byte wrong");
   a_base_high: assert property (wr && PADDR_I == 12'h180 |=> PORT_BASE_ADDR_O[15:8] == $past(PWDATA_I[7:0]))
      else $error("base high byte wrong");
   // Ten cycles wide; the repetition is split to stay small
   a_kb_pulse: assert property ($rose(KEYBOARD_RESET_PIN_OE_O) |-> KEYBOARD_RESET_PIN_OE_O[*8] ##1 KEYBOARD_RESET_PIN_OE_O ##1 KEYBOARD_RESET_PIN_OE_O ##1 !KEYBOARD_RESET_PIN_OE_O)
      else $error("keyboard reset pulse width wrong");
   a_rdata_upper: assert property (PRDATA_O[31:8] == 24'h000000)
      else $error("upper read data not zero");
   a_unmapped_err: assert property (PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == 12'h0C4 |-> PSLVERR_O && PRDATA_O == 32'h0)
      else $error("unmapped read not refused");
   a_reset_vals: assert property ($rose(RST_N_I) |-> !POWER_LED_O && PORT_BASE_ADDR_O == 16'h0000)
      else $error("reset values wrong");
endmodule

// [verif/lgwc_pins_model.sv]
`timescale 1ns/10ps
module lgwc_pins_model (
   input  wire logic [7:0] ext_i,
   input  wire logic [7:0] dout_i,
   input  wire logic [7:0] oe_i,
   output logic      [7:0] pin_o
);
   // Device driver wins where enabled; board strap level elsewhere
   assign pin_o = (oe_i & dout_i) | (~oe_i & ext_i);
endmodule

// [verif/tb_ld8_gpio_watchdog_ctrl.sv]
`timescale 1ns/10ps
`define CHK(a,e) begin comparisons++; if ((a)!==(e)) begin err_count++; $display("unexpected %0t got %h",$time,a); end end
module tb_ld8_gpio_watchdog_ctrl;
   logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0, keyboard_controller = 1'h0, kb_seen = 1'h0;
   logic        err, pready, slverr, kb_oe, kb_pin, watchdog_timeout_out_n, led;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] base;
   logic [7:0]  ext5 = 8'h00, ext6 = 8'h1F, p5, p6, o5, o6, oe5, oe6, d;
   int          err_count = 0, comparisons = 0, cyc = 0, n;
   always #50 clk = ~clk;
   lgwc_top #(.SEC_CYCLES(2000), .MIN_CYCLES(6000)) u_lgwc_top (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(slverr), .PORT_FIVE_PINS_I(p5), .PORT_FIVE_PINS_O(o5), .PORT_FIVE_PINS_OE_O(oe5),
      .PORT_SIX_PINS_I(p6), .PORT_SIX_PINS_O(o6), .PORT_SIX_PINS_OE_O(oe6), .KEYBOARD_CTRL_RESET_LINE_I(keyboard_controller),
      .KEYBOARD_RESET_PIN_O(kb_pin), .KEYBOARD_RESET_PIN_OE_O(kb_oe), .WATCHDOG_TIMEOUT_OUT_N_O(watchdog_timeout_out_n),
      .POWER_LED_O(led), .PORT_BASE_ADDR_O(base));
   lgwc_pins_model u_lgwc_pins_model5 (.ext_i(ext5), .dout_i(o5), .oe_i(oe5), .pin_o(p5));
   lgwc_pins_model u_lgwc_pins_model6 (.ext_i(ext6), .dout_i(o6), .oe_i(oe6), .pin_o(p6));
   ////////////////////////////////////////////////////////////
   task automatic results();
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      pen <= 1'h1;
      // Ends on the first edge that sees pready high
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      d = prdata[7:0];
      err = slverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   // First look one falling edge on, once the load edge has cleared the status
   task automatic wt(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (watchdog_timeout_out_n !== 1'h0 && n < lim);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [7:0] idx [11] = '{8'h30, 8'h60, 8'h61, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'hE6, 8'hE7, 8'hF5};
      logic [7:0] rv [11] = '{8'h02, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
      `CHK({o6, oe5, oe6}, 24'h1F0000)
      for (int i = 0; i < 11; i++) begin
         apb(1'h0, idx[i], 8'h00);
         `CHK(d, rv[i])
      end
      apb(1'h0, 8'h31, 8'h00);
      `CHK({err, d}, 9'h100)
   endtask
   task automatic t_out();
      ext5 <= 8'h30;
      apb(1'h1, 8'h30, 8'h07);
      apb(1'h1, 8'hE0, 8'hF0);
      apb(1'h1, 8'hE1, 8'hA5);
      @(negedge clk);
      `CHK({oe5, o5}, 16'h0F05)
      apb(1'h0, 8'hE1, 8'h00);
      `CHK(d, 8'h35)
      apb(1'h1, 8'hE2, 8'hFF);
      @(negedge clk);
      `CHK({o5, led}, 9'h1F5)
      apb(1'h0, 8'hE1, 8'h00);
      `CHK(d, 8'hC5)
      apb(1'h1, 8'hE2, 8'h00);
   endtask
   task automatic t_evt();
      repeat (4) @(posedge clk);
      apb(1'h0, 8'hE3, 8'h00);
      apb(1'h0, 8'hE7, 8'h00);
      ext5 <= ext5 ^ 8'h40;
      ext6 <= ext6 ^ 8'h01;
      repeat (4) @(posedge clk);
      apb(1'h0, 8'hE3, 8'h00);
      `CHK(d, 8'h40)
      apb(1'h0, 8'hE3, 8'h00);
      `CHK(d, 8'h00)
      apb(1'h1, 8'hE7, 8'hFF);
      apb(1'h0, 8'hE7, 8'h00);
      `CHK(d, 8'h01)
      ext5 <= ext5 ^ 8'h40;
      repeat (4) @(posedge clk);
      // Second edge reaches the status register on the read's clearing edge
      ext5 <= ext5 ^ 8'h40;
      apb(1'h0, 8'hE3, 8'h00);
      `CHK(d, 8'h40)
      apb(1'h0, 8'hE3, 8'h00);
      `CHK(d, 8'h40)
      apb(1'h0, 8'hE3, 8'h00);
      `CHK(d, 8'h00)
   endtask
   task automatic t_wd();
      int ns;
      apb(1'h1, 8'hF5, 8'hFF);
      apb(1'h0, 8'hF5, 8'h00);
      `CHK(d, 8'h1E)
      apb(1'h1, 8'hF5, 8'h12);
      apb(1'h1, 8'hF6, 8'h05);
      wt(100);
      ns = n;
      apb(1'h0, 8'hF7, 8'h00);
      `CHK({d[4], kb_seen}, 2'h3)
      apb(1'h1, 8'hF5, 8'h1A);
      apb(1'h1, 8'hF6, 8'h05);
      wt(100);
      `CHK(n > ns + 12, 1'h1)
      apb(1'h1, 8'hF5, 8'h00);
      apb(1'h1, 8'hF6, 8'h02);
      wt(4200);
      `CHK(n > 1000 && n < 4100, 1'h1)
      apb(1'h1, 8'hF7, 8'h00);
      apb(1'h1, 8'hF5, 8'h04);
      keyboard_controller <= 1'h1;
      wt(10);
      `CHK(watchdog_timeout_out_n, 1'h0)
      apb(1'h1, 8'hF7, 8'h00);
      apb(1'h1, 8'hF5, 8'h00);
      keyboard_controller <= 1'h0;
      repeat (4) @(posedge clk);
      keyboard_controller <= 1'h1;
      repeat (6) @(negedge clk);
      `CHK(watchdog_timeout_out_n, 1'h1)
   endtask
   task automatic t_act();
      apb(1'h1, 8'h60, 8'h0F);
      apb(1'h1, 8'h61, 8'hFF);
      apb(1'h1, 8'h30, 8'hF8);
      apb(1'h0, 8'h30, 8'h00);
      @(negedge clk);
      `CHK({d, base}, 24'h000FFC)
      `CHK({led, oe5}, 9'h000)
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc++;
      if (kb_oe === 1'h1 && kb_pin === 1'h0)
         kb_seen <= 1'h1;
      if (cyc == 9000) begin
         err_count++;
         results();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_reset();
      t_out();
      t_evt();
      t_wd();
      t_act();
      results();
   end
endmodule
bind lgwc_top lgwc_asserts u_lgwc_asserts (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O),
   .KEYBOARD_RESET_PIN_OE_O(KEYBOARD_RESET_PIN_OE_O), .WATCHDOG_TIMEOUT_OUT_N_O(WATCHDOG_TIMEOUT_OUT_N_O),
   .POWER_LED_O(POWER_LED_O), .PORT_BASE_ADDR_O(PORT_BASE_ADDR_O));
